/* File: shared/flash_host_pkg.sv */
/*
  Constants for the parallel flash host controller: command codes, pin timing counts, field
  positions. Assumes a 20 MHz system clock and an asynchronous parallel flash on the far side.
*/
// Operation
// - Chip erase ends with data 10 written at word address 5555.
// - Sector erase ends with data 30 written.
// - Final sector erase address selects the sector; only that sector erases.
// - Output enable stays high while write enable and chip select are low.
// - Host holds each strobe high pulse at least 150 ns while polling.
// - Toggle polling keeps one unchanged address between reads.
// - Commands use the low data byte; upper byte and byte-mode bit ignored.
package flash_host_pkg;
  localparam int CLK_MHZ = 20;
  localparam int STROBE_HIGH_MIN_TIME_NS = 150;
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_HIGH_NS = 40;
  localparam int READ_ACCESS_NS = 90;
  localparam int PROGRAM_MAX_US = 50;
  localparam int NS_PER_CYC = 1000 / CLK_MHZ;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_MIN_TIME_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int PROGRAM_MAX_CYC = PROGRAM_MAX_US * CLK_MHZ;
  localparam int TOGGLE_BIT = 6;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam logic [17:0] ADDR_UNLOCK1 = 18'h05555;
  localparam logic [17:0] ADDR_UNLOCK2 = 18'h02AAA;
  localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] DATA_ERASE_SETUP = 8'h80;
  localparam logic [7:0] DATA_CHIP_ERASE = 8'h10;
  localparam logic [7:0] DATA_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] DATA_PROGRAM = 8'hA0;
  localparam logic [7:0] DATA_ID_ENTRY = 8'h90;
  localparam logic [7:0] DATA_ID_EXIT = 8'hF0;
  localparam logic [7:0] DATA_LOCKOUT_SETUP = 8'h80;
  localparam logic [7:0] DATA_LOCKOUT = 8'h40;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_PROGRAM = 3'h1;
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h2;
  localparam logic [2:0] CMD_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] CMD_ID_ENTRY = 3'h4;
  localparam logic [2:0] CMD_ID_EXIT = 3'h5;
  localparam logic [2:0] CMD_LOCKOUT = 3'h6;
endpackage

/* File: src/flash_bus_cycle.sv */
/*
  One timed flash bus cycle: a write strobe or a read with data capture.
  Assumes the caller holds address and data steady while o_busy is high.
*/
`timescale 1ns/1ps
module flash_bus_cycle (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [15:0] i_data_in,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_data_oe
);
  localparam int CW = 8;
  localparam logic [CW-1:0] PULSE_W = CW'(flash_host_pkg::WRITE_PULSE_CYC);
  localparam logic [CW-1:0] READ_W = CW'(flash_host_pkg::READ_ACCESS_CYC + 2);
  localparam logic [CW-1:0] HIGH_W = CW'(flash_host_pkg::STROBE_HIGH_CYC);

  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} cyc_e;
  cyc_e state;
  logic is_write;
  logic [CW-1:0] cnt;

  // Data capture waits two extra cycles because the pins pass a two-stage synchroniser.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_data_oe <= 1'b0;
      o_rdata <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_start) begin
            state <= S_LOW;
            is_write <= i_write;
            cnt <= i_write ? PULSE_W : READ_W;
            o_ce_n <= 1'b0;
            o_oe_n <= i_write;
            o_we_n <= !i_write;
            o_data_oe <= i_write;
          end
        end
        S_LOW: begin
          if (cnt == CW'(1)) begin
            state <= S_HIGH;
            cnt <= HIGH_W;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            if (!is_write) begin
              o_rdata <= i_data_in;
            end
          end else begin
            cnt <= cnt - CW'(1);
          end
        end
        S_HIGH: begin
          if (cnt == CW'(1)) begin
            state <= S_IDLE;
            o_data_oe <= 1'b0;
            o_done <= 1'b1;
          end else begin
            cnt <= cnt - CW'(1);
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign o_busy = (state != S_IDLE);
endmodule

/* File: src/flash_host_ctrl.sv */
/*
  Host controller for an asynchronous parallel flash: runs unlock sequences, command writes,
  program, erase, identification entry and exit, lockout, reads and toggle-bit polling.
  Assumes one 20 MHz clock and a flash wired directly to the pins.
*/
`timescale 1ns/1ps
module flash_host_ctrl #(
  parameter int POLL_LIMIT = 20000000
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [2:0] i_req_cmd,
  input wire logic [17:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  output logic o_resp_valid,
  output logic [15:0] o_resp_rdata,
  output logic o_resp_timeout,
  output logic [17:0] o_flash_addr,
  output logic [15:0] o_flash_dq_out,
  output logic o_flash_dq_oe,
  input wire logic [15:0] i_flash_dq_in,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n,
  output logic o_flash_reset_n
);
  // Fewer than two polls can never see two reads agree, so elaboration stops.
  if (POLL_LIMIT < 2) begin : g_limit_check
    $error("POLL_LIMIT too small");
  end

  typedef enum logic [2:0] {S_IDLE, S_SEQ, S_WAIT, S_POLL, S_DONE} ctrl_e;
  ctrl_e state;
  logic [2:0] cmd;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic [31:0] poll_cnt;
  logic have_prev;
  logic prev_toggle;
  logic cyc_start;
  logic cyc_write;
  logic cyc_busy;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic [17:0] next_addr;
  logic [15:0] next_data;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= i_flash_dq_in;
      dq_sync <= dq_meta;
    end
  end

  // Step tables: every command but read is preceded by the two unlock writes.
  always_comb begin
    next_addr = flash_host_pkg::ADDR_UNLOCK1;
    next_data = {8'h00, flash_host_pkg::DATA_UNLOCK1};
    if (step == 3'h1 || step == 3'h4) begin
      next_addr = flash_host_pkg::ADDR_UNLOCK2;
      next_data = {8'h00, flash_host_pkg::DATA_UNLOCK2};
    end else if (step == 3'h3) begin
      next_data = {8'h00, flash_host_pkg::DATA_UNLOCK1};
    end else if (step == 3'h2) begin
      case (cmd)
        flash_host_pkg::CMD_PROGRAM: next_data = {8'h00, flash_host_pkg::DATA_PROGRAM};
        flash_host_pkg::CMD_ID_ENTRY: next_data = {8'h00, flash_host_pkg::DATA_ID_ENTRY};
        flash_host_pkg::CMD_ID_EXIT: next_data = {8'h00, flash_host_pkg::DATA_ID_EXIT};
        flash_host_pkg::CMD_LOCKOUT: next_data = {8'h00, flash_host_pkg::DATA_LOCKOUT_SETUP};
        default: next_data = {8'h00, flash_host_pkg::DATA_ERASE_SETUP};
      endcase
    end else if (step == 3'h5) begin
      case (cmd)
        flash_host_pkg::CMD_CHIP_ERASE: next_data = {8'h00, flash_host_pkg::DATA_CHIP_ERASE};
        flash_host_pkg::CMD_SECTOR_ERASE: begin
          next_addr = addr;
          next_data = {8'h00, flash_host_pkg::DATA_SECTOR_ERASE};
        end
        default: next_data = {8'h00, flash_host_pkg::DATA_LOCKOUT};
      endcase
    end
    if (cmd == flash_host_pkg::CMD_PROGRAM && step == 3'h3) begin
      next_addr = addr;
      next_data = wdata;
    end
    if (cmd == flash_host_pkg::CMD_READ || state == S_POLL) begin
      next_addr = addr;
      next_data = 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      cmd <= flash_host_pkg::CMD_READ;
      addr <= 18'h00000;
      wdata <= 16'h0000;
      step <= 3'h0;
      nsteps <= 3'h0;
      poll_cnt <= 32'h00000000;
      have_prev <= 1'b0;
      prev_toggle <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      o_flash_addr <= 18'h00000;
      o_flash_dq_out <= 16'h0000;
      o_resp_valid <= 1'b0;
      o_resp_rdata <= 16'h0000;
      o_resp_timeout <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      o_resp_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_req_valid) begin
            cmd <= i_req_cmd;
            addr <= i_req_addr;
            wdata <= i_req_wdata;
            step <= 3'h0;
            o_resp_timeout <= 1'b0;
            case (i_req_cmd)
              flash_host_pkg::CMD_READ: nsteps <= 3'h1;
              flash_host_pkg::CMD_PROGRAM: nsteps <= 3'h4;
              flash_host_pkg::CMD_ID_ENTRY: nsteps <= 3'h3;
              flash_host_pkg::CMD_ID_EXIT: nsteps <= 3'h3;
              default: nsteps <= 3'h6;
            endcase
            state <= S_SEQ;
          end
        end
        S_SEQ: begin
          o_flash_addr <= next_addr;
          o_flash_dq_out <= next_data;
          cyc_write <= (cmd != flash_host_pkg::CMD_READ);
          cyc_start <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (cmd == flash_host_pkg::CMD_READ || (step == nsteps && cyc_write == 1'b0)) begin
              if (have_prev && prev_toggle == cyc_rdata[flash_host_pkg::TOGGLE_BIT]) begin
                o_resp_rdata <= cyc_rdata;
                o_resp_valid <= 1'b1;
                have_prev <= 1'b0;
                state <= S_IDLE;
              end else if (cmd == flash_host_pkg::CMD_READ) begin
                o_resp_rdata <= cyc_rdata;
                o_resp_valid <= 1'b1;
                state <= S_IDLE;
              end else begin
                have_prev <= 1'b1;
                prev_toggle <= cyc_rdata[flash_host_pkg::TOGGLE_BIT];
                state <= S_POLL;
              end
            end else if (step + 3'h1 == nsteps) begin
              step <= nsteps;
              if (cmd == flash_host_pkg::CMD_PROGRAM || cmd == flash_host_pkg::CMD_CHIP_ERASE ||
                  cmd == flash_host_pkg::CMD_SECTOR_ERASE) begin
                poll_cnt <= 32'h00000000;
                have_prev <= 1'b0;
                state <= S_POLL;
              end else begin
                state <= S_DONE;
              end
            end else begin
              step <= step + 3'h1;
              state <= S_SEQ;
            end
          end
        end
        S_POLL: begin
          // Each poll is a full read whose high time already meets the strobe minimum.
          if (poll_cnt == 32'(POLL_LIMIT)) begin
            o_resp_timeout <= 1'b1;
            have_prev <= 1'b0;
            state <= S_DONE;
          end else begin
            poll_cnt <= poll_cnt + 32'h00000001;
            o_flash_addr <= next_addr;
            cyc_write <= 1'b0;
            cyc_start <= 1'b1;
            state <= S_WAIT;
          end
        end
        S_DONE: begin
          o_resp_rdata <= 16'h0000;
          o_resp_valid <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_data_in(dq_sync),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_ce_n(o_flash_ce_n),
    .o_oe_n(o_flash_oe_n),
    .o_we_n(o_flash_we_n),
    .o_data_oe(o_flash_dq_oe)
  );

  assign o_req_ready = (state == S_IDLE) && !cyc_busy;
  // The flash reset pin is held released; power cycling clears identification mode by itself.
  assign o_flash_reset_n = 1'b1;
endmodule

/* File: tb/flash_host_ctrl_sva.sv */
/*
  Concurrent checks on the flash host controller pins.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module flash_host_ctrl_sva (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic [2:0] i_req_cmd,
  input wire logic [17:0] i_req_addr,
  input wire logic [17:0] o_flash_addr,
  input wire logic [15:0] o_flash_dq_out,
  input wire logic o_flash_dq_oe,
  input wire logic o_flash_ce_n,
  input wire logic o_flash_oe_n,
  input wire logic o_flash_we_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [2:0] rc;
  logic [17:0] ra;
  wire take = i_req_valid && o_req_ready;
  wire wr = !o_flash_we_n && !o_flash_ce_n;
  wire at_u = wr && o_flash_addr == 18'h05555;
  // The accepted request is held so that later pin activity can be tied back to it.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rc <= 3'h0;
      ra <= 18'h00000;
    end else if (take) begin
      rc <= i_req_cmd;
      ra <= i_req_addr;
    end
  end
  property p_oe_wr; wr |-> o_flash_oe_n; endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("oe low in write");
  property p_dq_wr; wr |-> o_flash_dq_oe; endproperty
  a_dq_wr: assert property (p_dq_wr) else $error("data not driven in write");
  property p_dq_rd; !o_flash_oe_n |-> !o_flash_dq_oe; endproperty
  a_dq_rd: assert property (p_dq_rd) else $error("data driven during read");
  property p_oe_hi; $rose(o_flash_oe_n) |-> o_flash_oe_n [*3]; endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("oe high too short");
  property p_ce_hi; $rose(o_flash_ce_n) |-> o_flash_ce_n [*3]; endproperty
  a_ce_hi: assert property (p_ce_hi) else $error("ce high too short");
  property p_chip;
    take && i_req_cmd == flash_host_pkg::CMD_CHIP_ERASE |->
      ##[1:200] (at_u && o_flash_dq_out[7:0] == 8'h10);
  endproperty
  a_chip: assert property (p_chip) else $error("no chip erase write");
  property p_sect;
    take && i_req_cmd == flash_host_pkg::CMD_SECTOR_ERASE |->
      ##[1:200] (wr && o_flash_addr == ra && o_flash_dq_out[7:0] == 8'h30);
  endproperty
  a_sect: assert property (p_sect) else $error("no sector erase write");
  property p_poll;
    $fell(o_flash_oe_n) && rc == flash_host_pkg::CMD_PROGRAM && !o_req_ready
      |-> o_flash_addr == ra;
  endproperty
  a_poll: assert property (p_poll) else $error("poll address moved");
  property p_unl;
    take && i_req_cmd != flash_host_pkg::CMD_READ |->
      ##[1:60] (at_u && o_flash_dq_out[7:0] == 8'hAA);
  endproperty
  a_unl: assert property (p_unl) else $error("no unlock write");
  property p_hib; wr && rc != flash_host_pkg::CMD_PROGRAM |-> o_flash_dq_out[15:8] == 8'h00;
  endproperty
  a_hib: assert property (p_hib) else $error("command upper byte set");
  property p_exit;
    take && i_req_cmd == flash_host_pkg::CMD_ID_EXIT |->
      ##[1:100] (at_u && o_flash_dq_out[7:0] == 8'hF0);
  endproperty
  a_exit: assert property (p_exit) else $error("no exit write");
  c_sect: cover property (take && i_req_cmd == flash_host_pkg::CMD_SECTOR_ERASE);
  c_poll: cover property ($fell(o_flash_oe_n) && rc == flash_host_pkg::CMD_PROGRAM);
  c_lock: cover property (take && i_req_cmd == flash_host_pkg::CMD_LOCKOUT);
endmodule
bind flash_host_ctrl flash_host_ctrl_sva i_flash_host_ctrl_sva (.*);

/* File: tb/flash_dev_model.sv */
/*
  Behavioural parallel flash: 16 words, four sectors of four, command decoder.
  Assumes the host drives strobes and data; no pull-ups on the data lines.
*/
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0A5C,
  parameter logic [15:0] PART_CODE = 16'h3C81
) (
  input wire logic [17:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [15:0] o_dq
);
  // Both identity defaults are arbitrary values.
  logic [15:0] mem [16];
  logic [23:0] h [6];
  logic id_mode = 1'b0;
  logic locked = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  wire rd_on = !i_ce_n && !i_oe_n;
  wire wr_on = !i_ce_n && !i_we_n;
  function automatic logic ul(int j);
    return h[j+1] == 24'h5555AA && h[j] == 24'h2AAA55;
  endfunction
  initial foreach (mem[k]) mem[k] = 16'h0000;
  // A write latches when the first of its two strobes rises, since both may rise together.
  always @(negedge wr_on) begin
    for (int k = 5; k > 0; k--) h[k] = h[k-1];
    h[0] = {i_addr[15:0], i_dq[7:0]};
    if (h[0][7:0] == 8'hF0) id_mode = 1'b0;
    if (ul(1) && h[0] == 24'h555590) id_mode = 1'b1;
    if (ul(2) && h[1] == 24'h5555A0 && !(locked && i_addr[3:2] == 2'h0)) begin
      mem[i_addr[3:0]] = i_dq;
      busy = 1'b1;
      busy <= #5000 1'b0;
    end
    if (ul(4) && h[3] == 24'h555580 && ul(1)) begin
      if (h[0] == 24'h555540) locked = 1'b1;
      if (h[0] == 24'h555510 || h[0][7:0] == 8'h30) begin
        foreach (mem[k])
          if (!(locked && k < 4) && (h[0][7:0] == 8'h10 || k[3:2] == i_addr[3:2]))
            mem[k] = 16'hFFFF;
        busy = 1'b1;
        busy <= #10000 1'b0;
      end
    end
  end
  always @(posedge rd_on) if (busy) tog = ~tog;
  always @* begin
    if (busy) rd = {9'h000, tog, 6'h00};
    else if (id_mode) rd = i_addr[0] ? PART_CODE : MAKER_CODE;
    else rd = mem[i_addr[3:0]];
  end
  // A released bus shows the inverse, so a stale capture cannot pass.
  always @(negedge rd_on) last = rd;
  assign o_dq = rd_on ? rd : ~last;
endmodule

/* File: tb/test_parallel_flash_command_status.sv */
/*
  Self-checking bench for the flash host controller against a behavioural flash.
  Assumes the package, design, checker and model compile first.
*/
`timescale 1ns/1ps
module test_parallel_flash_command_status;
  localparam logic [15:0] MAKER = 16'h0A5C; // Arbitrary identity value.
  localparam logic [15:0] PART = 16'h3C81; // Arbitrary identity value.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [17:0] addr = 18'h00000;
  logic [15:0] wdata = 16'h0000;
  logic ready, resp, tmo, dq_oe, ce_n, oe_n, we_n;
  logic rpin;
  logic [17:0] fa, ad;
  logic [15:0] rdata, dq_out, dq_in;
  logic [15:0] exp_mem [16];
  int fail_count = 0;
  int tests_run = 0;
  int seed = 29;
  flash_host_ctrl #(.POLL_LIMIT(50)) i_flash_host_ctrl (.i_clk_sys(clk), .i_resetn(rst_n),
    .i_req_valid(valid), .o_req_ready(ready), .i_req_cmd(cmd), .i_req_addr(addr),
    .i_req_wdata(wdata), .o_resp_valid(resp), .o_resp_rdata(rdata), .o_resp_timeout(tmo),
    .o_flash_addr(fa), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq_in),
    .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_reset_n(rpin));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash_dev_model (.i_addr(fa),
    .i_dq(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(dq_in));
  initial forever #25 clk = ~clk;
  // Whole run is a few thousand cycles, so 2 ms only trips on a hang.
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic req(logic [2:0] c, logic [17:0] a, logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd = c;
    addr = a;
    wdata = d;
    valid = 1'b1;
    while (!ready) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
    while (resp !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("resp", 16'h0001, {15'h0000, resp});
    chk("timeout", 16'h0000, {15'h0000, tmo});
  endtask
  function automatic logic hit(int k, logic [17:0] a, logic chip, logic lk);
    return !(lk && k < 4) && (chip || k[3:2] == a[3:2]);
  endfunction
  task automatic read_all();
    for (int k = 0; k < 16; k++) begin
      ad = 18'($random(seed));
      ad[3:0] = k[3:0];
      req(flash_host_pkg::CMD_READ, ad, 16'h0000);
      chk("array", exp_mem[k], rdata);
    end
  endtask
  task automatic erase(logic [2:0] c, logic [17:0] a, logic lk);
    req(c, a, 16'h0000);
    for (int k = 0; k < 16; k++)
      if (hit(k, a, c == flash_host_pkg::CMD_CHIP_ERASE, lk)) exp_mem[k] = 16'hFFFF;
    read_all();
  endtask
  task automatic prog(logic lk);
    logic [15:0] d;
    d = 16'($random(seed));
    req(flash_host_pkg::CMD_PROGRAM, ad, d);
    if (!(lk && ad[3:2] == 2'h0)) exp_mem[ad[3:0]] = d;
  endtask
  initial begin
    foreach (exp_mem[k]) exp_mem[k] = 16'h0000;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("reset pin", 16'h0001, {15'h0000, rpin});
    read_all();
    erase(flash_host_pkg::CMD_CHIP_ERASE, 18'h00000, 1'b0);
    for (int i = 0; i < 12; i++) begin
      ad = 18'($random(seed));
      prog(1'b0);
    end
    read_all();
    erase(flash_host_pkg::CMD_SECTOR_ERASE, 18'($random(seed)), 1'b0);
    req(flash_host_pkg::CMD_ID_ENTRY, 18'h00000, 16'h0000);
    req(flash_host_pkg::CMD_READ, 18'h00000, 16'h0000);
    chk("maker", MAKER, rdata);
    req(flash_host_pkg::CMD_READ, 18'h00001, 16'h0000);
    chk("part", PART, rdata);
    req(flash_host_pkg::CMD_ID_EXIT, 18'h00000, 16'h0000);
    read_all();
    req(flash_host_pkg::CMD_LOCKOUT, 18'h00000, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      ad = 18'($random(seed));
      ad[3:2] = i[1:0];
      prog(1'b1);
    end
    erase(flash_host_pkg::CMD_CHIP_ERASE, 18'h00000, 1'b1);
    close_out();
  end
endmodule
